//--- lvdcs_pkg.sv
// Constants for the low-voltage detect status and control bank.
// Assumes one synchronous clock domain and a single-cycle register port.
package lvdcs_pkg;

    // ************************************************************
    // Register offsets (register index on the plain port)
    // ************************************************************
    localparam int OFS_W = 2;
    localparam logic [OFS_W-1:0] OFS_CTRL = 2'h0;
    localparam logic [OFS_W-1:0] OFS_EVT_STATUS = 2'h1;
    localparam logic [OFS_W-1:0] OFS_EVT_MASK = 2'h2;

    // ************************************************************
    // Status and control field positions
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int BIT_WARN_FLAG = 7;
    localparam int BIT_WARN_ACK = 6;
    localparam int BIT_WARN_IE = 5;
    localparam int BIT_RESET_EN = 4;
    localparam int BIT_STOP_EN = 3;
    localparam int BIT_DETECT_EN = 2;
    localparam int BIT_DRIVE_SEL = 1;
    localparam int BIT_BUF_EN = 0;
    localparam logic [DATA_W-1:0] RST_CTRL = 8'h1c;

    // ************************************************************
    // Event status and mask layout
    // ************************************************************
    localparam int EVT_W = 2;
    localparam int EVT_WARN = 0;
    localparam int EVT_DETECT = 1;
    localparam logic [EVT_W-1:0] RST_EVT_MASK = 2'h0;

endpackage : lvdcs_pkg

//--- lvdcs_evt_if.sv
// Carrier between the control core and its event status bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface lvdcs_evt_if;
    import lvdcs_pkg::*;
    logic [EVT_W-1:0] event_pulse;
    logic status_rd_clear;
    logic mask_wr;
    logic [EVT_W-1:0] mask_wdata;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic irq;

    modport core (
        output event_pulse, status_rd_clear, mask_wr, mask_wdata,
        input status, mask, irq
    );
    modport bank (
        input event_pulse, status_rd_clear, mask_wr, mask_wdata,
        output status, mask, irq
    );
endinterface : lvdcs_evt_if

//--- lvdcs_evt_bank.sv
// Sticky event status, mask and interrupt level for the detect block.
// Assumes event pulses and strobes are synchronous to core_clk.
`timescale 1ns/100ps
module lvdcs_evt_bank
    import lvdcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Core side
    lvdcs_evt_if.bank evt
);

    typedef struct packed {
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic irq;
    } lvdcs_bank_t;

    localparam lvdcs_bank_t BANK_RST = '{
        status: '0, mask: RST_EVT_MASK, irq: 1'b0};

    lvdcs_bank_t st;
    lvdcs_bank_t next_st;

    always_comb begin
        next_st = st;
        // A read clears, but a fresh event in that cycle survives
        if (evt.status_rd_clear) begin
            next_st.status = '0;
        end
        next_st.status = next_st.status | evt.event_pulse;
        if (evt.mask_wr) begin
            next_st.mask = evt.mask_wdata;
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= BANK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign evt.status = st.status;
    assign evt.mask = st.mask;
    assign evt.irq = st.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    set_wins_a: assert property (@(posedge core_clk) disable iff (!rstn)
        evt.event_pulse[EVT_WARN] |=> evt.status[EVT_WARN])
        else $error("event lost against read clear");
    irq_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (evt.status[EVT_DETECT] && evt.mask[EVT_DETECT]) |-> evt.irq)
        else $error("unmasked event without interrupt");

endmodule // lvdcs_evt_bank

//--- lvdcs_core.sv
// Low-voltage detect status and control register with its qualifiers.
// Assumes supply comparator levels arrive synchronous to core_clk.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps

// Overview of operation
// R1 - Warning flag sets while supply below trip
// R2 - Warning flag sticky until acknowledged
// R3 - Software acknowledges before enabling warning interrupt
// R4 - Acknowledge clears flag only once supply recovered
// R5 - Interrupt enable requests interrupt while flag set
// R6 - Enabled detect event forces reset when armed
// R7 - Detect reset enable accepts first write only
// R8 - Stop enable keeps detection alive in stop
// R9 - Detect enable write-once, gates other functions
// R10 - Drive select picks high or low drive
// R11 - Buffer enable powers the bandgap buffer
// R12 - Enabled detection sets flag, raises interrupt
// R13 - Stop disables detect unless stop/debug enable
// R14 - Acknowledge reads zero, zero write harmless
module lvdcs_core
    import lvdcs_pkg::*;
#(
    parameter int ADDR_W = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Analog and system status
    input wire logic warn_below,
    input wire logic detect_below,
    input wire logic stop_mode,
    input wire logic background_debug_enable,
    // Control outputs
    output logic detect_active,
    output logic detect_reset_req,
    output logic warning_irq,
    output logic bandgap_buffer_on,
    output logic bandgap_high_drive,
    output logic irq
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    if (ADDR_W < OFS_W) begin : g_bad_addr_w
        $error("ADDR_W too narrow for the register map");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic warning_flag;
        logic warning_interrupt_enable;
        logic detect_reset_enable;
        logic detect_stop_enable;
        logic detect_enable;
        logic bandgap_drive_select;
        logic bandgap_buffer_enable;
        logic write_locked;
        logic detect_prev;
        logic detect_active;
        logic detect_reset_req;
        logic warning_irq;
        logic buf_on;
        logic buf_hi;
        logic [DATA_W-1:0] rdata;
    } lvdcs_core_t;

    localparam lvdcs_core_t CORE_RST = '{
        warning_flag: RST_CTRL[BIT_WARN_FLAG],
        warning_interrupt_enable: RST_CTRL[BIT_WARN_IE],
        detect_reset_enable: RST_CTRL[BIT_RESET_EN],
        detect_stop_enable: RST_CTRL[BIT_STOP_EN],
        detect_enable: RST_CTRL[BIT_DETECT_EN],
        bandgap_drive_select: RST_CTRL[BIT_DRIVE_SEL],
        bandgap_buffer_enable: RST_CTRL[BIT_BUF_EN],
        write_locked: 1'b0,
        detect_prev: 1'b0,
        detect_active: 1'b0,
        detect_reset_req: 1'b0,
        warning_irq: 1'b0,
        buf_on: 1'b0,
        buf_hi: 1'b0,
        rdata: '0};

    lvdcs_core_t st;
    lvdcs_core_t next_st;

    lvdcs_evt_if evt ();

    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] a,
        input logic [OFS_W-1:0] ofs
    );
        reg_hit = (a == ADDR_W'(ofs));
    endfunction

    // ************************************************************
    // Detect qualification
    // ************************************************************
    logic running;
    logic warn_set;
    logic detect_now;
    logic ctrl_wr;
    logic ack_wr;

    // In stop the comparator only stays on if asked to
    assign running = st.detect_enable
        && (!stop_mode || st.detect_stop_enable
            || background_debug_enable); // [R13] [R8] [R9]
    assign warn_set = running && warn_below; // [R1] [R12]
    assign detect_now = running && detect_below;
    assign ctrl_wr = reg_wr && reg_hit(reg_addr, OFS_CTRL);
    assign ack_wr = ctrl_wr && reg_wdata[BIT_WARN_ACK]; // [R14]

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        if (ctrl_wr) begin
            next_st.warning_interrupt_enable = reg_wdata[BIT_WARN_IE];
            next_st.detect_stop_enable = reg_wdata[BIT_STOP_EN]; // [R8]
            next_st.bandgap_drive_select = reg_wdata[BIT_DRIVE_SEL];
            next_st.bandgap_buffer_enable = reg_wdata[BIT_BUF_EN];
            // One lock for both once-only bits: any later write is void
            if (!st.write_locked) begin
                next_st.detect_reset_enable =
                    reg_wdata[BIT_RESET_EN]; // [R7]
                next_st.detect_enable = reg_wdata[BIT_DETECT_EN]; // [R9]
                next_st.write_locked = 1'b1; // [R7] [R9]
            end
        end
        // Acknowledge is refused while the supply is still low
        if (ack_wr && !warn_below) begin
            next_st.warning_flag = 1'b0; // [R4]
        end
        if (warn_set) begin
            next_st.warning_flag = 1'b1; // [R1] [R2]
        end
        next_st.detect_prev = detect_now;
        next_st.detect_active = running; // [R13]
        next_st.detect_reset_req =
            detect_now && st.detect_reset_enable; // [R6]
        next_st.warning_irq =
            next_st.warning_flag
            && next_st.warning_interrupt_enable; // [R5] [R12]
        next_st.buf_on = next_st.bandgap_buffer_enable; // [R11]
        next_st.buf_hi = next_st.bandgap_buffer_enable
            && next_st.bandgap_drive_select; // [R10]
        next_st.rdata = '0;
        if (reg_rd) begin
            if (reg_hit(reg_addr, OFS_CTRL)) begin
                next_st.rdata = {st.warning_flag, 1'b0,
                    st.warning_interrupt_enable, st.detect_reset_enable,
                    st.detect_stop_enable, st.detect_enable,
                    st.bandgap_drive_select,
                    st.bandgap_buffer_enable}; // [R14]
            end else if (reg_hit(reg_addr, OFS_EVT_STATUS)) begin
                next_st.rdata = DATA_W'(evt.status);
            end else if (reg_hit(reg_addr, OFS_EVT_MASK)) begin
                next_st.rdata = DATA_W'(evt.mask);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= CORE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Event bank
    // ************************************************************
    // Warning event marks the flag's rise, so a cleared status does not
    // refire while the supply stays low
    assign evt.event_pulse[EVT_WARN] = warn_set && !st.warning_flag;
    assign evt.event_pulse[EVT_DETECT] = detect_now && !st.detect_prev;
    assign evt.status_rd_clear = reg_rd
        && reg_hit(reg_addr, OFS_EVT_STATUS);
    assign evt.mask_wr = reg_wr && reg_hit(reg_addr, OFS_EVT_MASK);
    assign evt.mask_wdata = reg_wdata[EVT_W-1:0];

    lvdcs_evt_bank u_evt_bank (
        .core_clk(core_clk),
        .rstn(rstn),
        .evt(evt.bank)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata = st.rdata;
    assign detect_active = st.detect_active;
    assign detect_reset_req = st.detect_reset_req;
    assign warning_irq = st.warning_irq;
    assign bandgap_buffer_on = st.buf_on;
    assign bandgap_high_drive = st.buf_hi;
    assign irq = evt.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    flag_set_a: assert property ( // [R1]
        (running && warn_below) |=> st.warning_flag)
        else $error("warning flag not set on low supply");
    flag_sticky_a: assert property ( // [R2]
        (st.warning_flag && !ack_wr) |=> st.warning_flag)
        else $error("warning flag dropped without acknowledge");
    ack_clears_a: assert property ( // [R4]
        (ack_wr && !warn_below) |=> !st.warning_flag)
        else $error("acknowledge did not clear flag");
    ack_refused_a: assert property ( // [R4]
        (st.warning_flag && warn_below) |=> st.warning_flag)
        else $error("flag cleared while supply still low");
    warn_irq_a: assert property ( // [R5]
        warning_irq
            == (st.warning_flag && st.warning_interrupt_enable))
        else $error("warning interrupt request mismatch");
    reset_req_a: assert property ( // [R6]
        detect_reset_req |-> $past(st.detect_reset_enable
            && st.detect_enable && detect_below))
        else $error("detect reset without its enables");
    once_lock_a: assert property ( // [R7]
        (st.write_locked && ctrl_wr) |=>
            $stable(st.detect_reset_enable) && $stable(st.detect_enable))
        else $error("write-once bit changed after lock");
    stop_gate_a: assert property ( // [R13]
        (stop_mode && !st.detect_stop_enable
            && !background_debug_enable) |=> !detect_active)
        else $error("detection active in stop without enable");
    drive_sel_a: assert property ( // [R10]
        bandgap_high_drive |-> bandgap_buffer_on)
        else $error("high drive without buffer enable");
    buf_en_a: assert property ( // [R11]
        ctrl_wr |=> bandgap_buffer_on
            == $past(reg_wdata[BIT_BUF_EN]))
        else $error("buffer enable not followed");
    ack_reads_zero_a: assert property ( // [R14]
        (reg_rd && reg_hit(reg_addr, OFS_CTRL)) |=>
            !reg_rdata[BIT_WARN_ACK])
        else $error("acknowledge bit read as one");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");

    // ************************************************************
    // Field write checks
    // ************************************************************
    wie_write_a: assert property ( // [R5]
        ctrl_wr
        |=> st.warning_interrupt_enable == $past(reg_wdata[BIT_WARN_IE]))
        else $error("interrupt enable write lost");
    stop_write_a: assert property ( // [R8]
        ctrl_wr
        |=> st.detect_stop_enable == $past(reg_wdata[BIT_STOP_EN]))
        else $error("stop enable write lost");
    drive_write_a: assert property ( // [R10]
        ctrl_wr
        |=> st.bandgap_drive_select == $past(reg_wdata[BIT_DRIVE_SEL]))
        else $error("drive select write lost");
    first_write_a: assert property ( // [R7] [R9]
        (ctrl_wr && !st.write_locked)
        |=> st.detect_enable == $past(reg_wdata[BIT_DETECT_EN])
            && st.detect_reset_enable == $past(reg_wdata[BIT_RESET_EN]))
        else $error("first control write not taken");
    lock_sets_a: assert property ( // [R7]
        ctrl_wr |=> st.write_locked)
        else $error("control write left once-only bits open");
    lock_holds_a: assert property ( // [R9]
        st.write_locked |=> st.write_locked)
        else $error("write lock released before reset");
    no_write_keep_a: assert property ( // [R9]
        !ctrl_wr |=> $stable(st.detect_enable))
        else $error("detect enable changed without a write");
    ack_zero_keep_a: assert property ( // [R14]
        (ctrl_wr && !reg_wdata[BIT_WARN_ACK] && st.warning_flag)
        |=> st.warning_flag)
        else $error("zero acknowledge cleared the flag");

    // ************************************************************
    // Detect and output checks
    // ************************************************************
    req_set_a: assert property ( // [R6]
        (running && detect_below && st.detect_reset_enable)
        |=> detect_reset_req)
        else $error("armed detect event gave no reset request");
    req_off_a: assert property ( // [R6]
        !st.detect_reset_enable |=> !detect_reset_req)
        else $error("reset request with reset enable clear");
    detect_event_a: assert property ( // [R6]
        (running && detect_below && !st.detect_prev)
        |=> evt.status[EVT_DETECT])
        else $error("detect event not recorded");
    detect_off_a: assert property ( // [R9]
        !st.detect_enable |=> !detect_active && !detect_reset_req)
        else $error("detection running while disabled");
    no_warn_off_a: assert property ( // [R12]
        (!running && !st.warning_flag) |=> !st.warning_flag)
        else $error("warning flag set with detection off");
    stop_keep_a: assert property ( // [R8]
        (st.detect_enable && st.detect_stop_enable) |=> detect_active)
        else $error("stop enable did not keep detection on");
    debug_keep_a: assert property ( // [R13]
        (st.detect_enable && background_debug_enable) |=> detect_active)
        else $error("debug enable did not keep detection on");
    stop_off_req_a: assert property ( // [R13]
        (stop_mode && !st.detect_stop_enable && !background_debug_enable)
        |=> !detect_reset_req)
        else $error("reset request while detection stopped");
    run_keep_a: assert property ( // [R9]
        (st.detect_enable && !stop_mode) |=> detect_active)
        else $error("detection off outside stop");
    warn_event_a: assert property ( // [R1]
        (running && warn_below && !st.warning_flag)
        |=> evt.status[EVT_WARN])
        else $error("warning event not recorded");
    warn_irq_off_a: assert property ( // [R5]
        !st.warning_flag |-> !warning_irq)
        else $error("warning interrupt without flag");
    high_drive_a: assert property ( // [R10]
        (bandgap_buffer_on && st.bandgap_drive_select)
        |-> bandgap_high_drive)
        else $error("high drive not applied");

    warn_ack_c: cover property (
        st.warning_flag ##1 (ack_wr && !warn_below) ##1 !st.warning_flag);
    reset_req_c: cover property (detect_reset_req);
    irq_c: cover property (irq && warning_irq);
    stop_keep_c: cover property (stop_mode && detect_active);
    lock_c: cover property (ctrl_wr && st.write_locked);

endmodule // lvdcs_core

//--- tb_lvdcs_core.sv
// Self-checking bench for the low-voltage detect status and control bank.
// Assumes lvdcs_core, its package, interface and event bank are compiled.
`timescale 1ns/100ps
module tb_lvdcs_core;
    import lvdcs_pkg::*;

    logic core_clk, rstn, reg_wr, reg_rd;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic warn_below, detect_below, stop_mode, background_debug_enable;
    logic detect_active, detect_reset_req, warning_irq;
    logic bandgap_buffer_on, bandgap_high_drive, irq;
    int fail_count = 0;
    int checks = 0;

    lvdcs_core #(.ADDR_W(2)) lvdcs_core_i (
        .core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .warn_below(warn_below), .detect_below(detect_below),
        .stop_mode(stop_mode),
        .background_debug_enable(background_debug_enable),
        .detect_active(detect_active), .detect_reset_req(detect_reset_req),
        .warning_irq(warning_irq), .bandgap_buffer_on(bandgap_buffer_on),
        .bandgap_high_drive(bandgap_high_drive), .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ************************************************************
    // Bus tasks and comparisons
    // ************************************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic do_reset(input int n);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (n) @(posedge core_clk);
        rstn <= 1'b1;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rv = reg_rdata;
        chk8(rv, exp);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_vals();
        rdchk(OFS_CTRL, RST_CTRL);
        rdchk(OFS_EVT_MASK, 8'h00);
        rdchk(OFS_EVT_STATUS, 8'h00);
        wr(2'h3, 8'hff);
        rdchk(2'h3, 8'h00);
        rdchk(OFS_CTRL, RST_CTRL);
        chk1(detect_active, 1'b1);
    endtask

    // Supply already low across reset, then acknowledge attempts
    task automatic t_warn();
        @(posedge core_clk);
        warn_below <= 1'b1;
        do_reset(2);
        settle(3);
        rdchk(OFS_CTRL, 8'h9c);
        chk1(warning_irq, 1'b0);
        wr(OFS_CTRL, 8'h5c);
        settle(1);
        rdchk(OFS_CTRL, 8'h9c);
        @(posedge core_clk);
        warn_below <= 1'b0;
        settle(2);
        rdchk(OFS_CTRL, 8'h9c);
        wr(OFS_CTRL, 8'h1c);
        settle(1);
        rdchk(OFS_CTRL, 8'h9c);
        wr(OFS_CTRL, 8'h5c);
        settle(1);
        rdchk(OFS_CTRL, 8'h1c);
        rdchk(OFS_EVT_STATUS, 8'h01);
        rdchk(OFS_EVT_STATUS, 8'h00);
    endtask

    task automatic t_irq();
        do_reset(2);
        wr(OFS_EVT_MASK, 8'h01);
        wr(OFS_CTRL, 8'h5c);
        wr(OFS_CTRL, 8'h3c);
        settle(1);
        chk1(warning_irq, 1'b0);
        chk1(irq, 1'b0);
        @(posedge core_clk);
        warn_below <= 1'b1;
        settle(3);
        chk1(warning_irq, 1'b1);
        chk1(irq, 1'b1);
        rdchk(OFS_EVT_MASK, 8'h01);
        rdchk(OFS_EVT_STATUS, 8'h01);
        settle(1);
        chk1(irq, 1'b0);
        wr(OFS_CTRL, 8'h1c);
        settle(1);
        chk1(warning_irq, 1'b0);
        rdchk(OFS_CTRL, 8'h9c);
        @(posedge core_clk);
        warn_below <= 1'b0;
    endtask

    // Reset enable honoured once, then locked by the first write
    task automatic t_detect();
        do_reset(2);
        @(posedge core_clk);
        detect_below <= 1'b1;
        settle(2);
        chk1(detect_reset_req, 1'b1);
        rdchk(OFS_EVT_STATUS, 8'h02);
        @(posedge core_clk);
        detect_below <= 1'b0;
        settle(2);
        chk1(detect_reset_req, 1'b0);
        wr(OFS_CTRL, 8'h0c);
        wr(OFS_CTRL, 8'h1c);
        settle(1);
        rdchk(OFS_CTRL, 8'h0c);
        @(posedge core_clk);
        detect_below <= 1'b1;
        settle(2);
        chk1(detect_reset_req, 1'b0);
        chk1(detect_active, 1'b1);
        @(posedge core_clk);
        detect_below <= 1'b0;
    endtask

    task automatic t_detect_off();
        do_reset(2);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_CTRL, 8'h04);
        settle(1);
        rdchk(OFS_CTRL, 8'h00);
        chk1(detect_active, 1'b0);
        @(posedge core_clk);
        warn_below <= 1'b1;
        detect_below <= 1'b1;
        settle(3);
        rdchk(OFS_CTRL, 8'h00);
        chk1(detect_reset_req, 1'b0);
        @(posedge core_clk);
        warn_below <= 1'b0;
        detect_below <= 1'b0;
    endtask

    task automatic t_stop();
        do_reset(2);
        @(posedge core_clk);
        stop_mode <= 1'b1;
        settle(2);
        chk1(detect_active, 1'b1);
        wr(OFS_CTRL, 8'h14);
        settle(1);
        chk1(detect_active, 1'b0);
        @(posedge core_clk);
        detect_below <= 1'b1;
        settle(2);
        chk1(detect_reset_req, 1'b0);
        @(posedge core_clk);
        background_debug_enable <= 1'b1;
        settle(2);
        chk1(detect_active, 1'b1);
        chk1(detect_reset_req, 1'b1);
        wr(OFS_CTRL, 8'h1c);
        @(posedge core_clk);
        background_debug_enable <= 1'b0;
        settle(2);
        chk1(detect_active, 1'b1);
        @(posedge core_clk);
        stop_mode <= 1'b0;
        detect_below <= 1'b0;
    endtask

    task automatic t_bandgap();
        logic [7:0] tbl [4];
        tbl = '{8'h1d, 8'h1f, 8'h1e, 8'h1c};
        do_reset(2);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, tbl[i]);
            settle(1);
            chk1(bandgap_buffer_on, tbl[i][0]);
            chk1(bandgap_high_drive, tbl[i][0] & tbl[i][1]);
            rdchk(OFS_CTRL, tbl[i]);
        end
    endtask

    // ************************************************************
    // Verdict and main sequence
    // ************************************************************
    task automatic wrap_up();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Whole run is under two hundred cycles; the 20000-cycle limit leaves ample margin
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        warn_below = 1'b0;
        detect_below = 1'b0;
        stop_mode = 1'b0;
        background_debug_enable = 1'b0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        settle(1);
        t_reset_vals();
        t_warn();
        t_irq();
        t_detect();
        t_detect_off();
        t_stop();
        t_bandgap();
        wrap_up();
    end
endmodule // tb_lvdcs_core
